// >>> shared/e1ecs_pkg.sv
// Purpose: Shared constants for the E1 error counter and signaling block
// Assumes: 10 MHz core clock, 8-bit host register port
// Notes:   Offsets are byte addresses of the host port
package e1ecs_pkg;
    // ******************************************************
    // Clock and interval timing
    // ******************************************************
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned INTERVAL_MS     = 1000;
    localparam int unsigned INTERVAL_CYCLES = CLK_HZ / 1000 * INTERVAL_MS;
    // 62.5 ms is one sixteenth of the second
    localparam int unsigned FAST_DIV        = 16;
    localparam int unsigned TMR_W           = 24;

    // ******************************************************
    // Register map
    // ******************************************************
    localparam logic [5:0] VIOL_HI_OFS  = 6'h00;
    localparam logic [5:0] VIOL_LO_OFS  = 6'h01;
    localparam logic [5:0] CRC_HI_OFS   = 6'h02;
    localparam logic [5:0] CRC_LO_OFS   = 6'h03;
    localparam logic [5:0] FEBE_HI_OFS  = 6'h04;
    localparam logic [5:0] FEBE_LO_OFS  = 6'h05;
    localparam logic [5:0] ALIGN_HI_OFS = 6'h06;
    localparam logic [5:0] ALIGN_LO_OFS = 6'h07;
    localparam logic [5:0] SIG_FIRST_OFS = 6'h30;
    localparam logic [5:0] SIG_LAST_OFS  = 6'h3f;
    localparam int unsigned NUM_SIG     = 16;
    localparam int unsigned NUM_CNT     = 4;
    localparam int unsigned CNT_W       = 16;

    // ******************************************************
    // Counter indices and status bit positions
    // ******************************************************
    localparam int unsigned CNT_VIOL  = 0;
    localparam int unsigned CNT_CRC   = 1;
    localparam int unsigned CNT_FEBE  = 2;
    localparam int unsigned CNT_ALIGN = 3;
    localparam int unsigned RMF_BIT   = 7;
    localparam int unsigned TMF_BIT   = 5;
    localparam int unsigned SEC_BIT   = 4;
    localparam logic [3:0] EBIT_FRAME_A = 4'hd;
    localparam logic [3:0] EBIT_FRAME_B = 4'hf;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [15:0] CNT_RST   = 16'h0000;
endpackage

// >>> shared/e1ecs_cnt_if.sv
// Purpose: Carrier between the top and one saturating error counter
// Assumes: Single core clock
// Notes:   Tick closes an interval and latches the snapshot
`timescale 1ns/100ps
interface e1ecs_cnt_if;
    logic        inc;
    logic        tick;
    logic [15:0] snap;
    modport ctl (output inc, output tick, input snap);
    modport cnt (input inc, input tick, output snap);
endinterface

// >>> rtl/e1ecs_satcnt.sv
// Purpose: 16-bit saturating error counter with interval snapshot
// Assumes: inc and tick are one-cycle pulses on the core clock
// Notes:   An event in the tick cycle opens the new interval
`timescale 1ns/100ps
module e1ecs_satcnt
    import e1ecs_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    e1ecs_cnt_if.cnt  c
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] snap_r;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            count_r <= CNT_RST;
        end else if (c.tick) begin
            count_r <= c.inc ? 16'h0001 : CNT_RST;
        end else if (c.inc && count_r != 16'hffff) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // One register for both bytes keeps a read pair coherent
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            snap_r <= CNT_RST;
        end else if (c.tick) begin
            snap_r <= count_r;
        end
    end

    assign c.snap = snap_r;

    a_snap_on_tick: assert property (@(posedge i_core_clk)
        disable iff (i_rst) c.tick |=> snap_r == $past(count_r))
        else $error("snapshot not taken on tick");
    a_sat_no_wrap: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (count_r == 16'hffff && !c.tick) |=> count_r == 16'hffff)
        else $error("counter wrapped past maximum");
    a_snap_stable: assert property (@(posedge i_core_clk)
        disable iff (i_rst) !c.tick |=> $stable(snap_r))
        else $error("snapshot changed between ticks");
endmodule

// >>> rtl/e1ecs_top.sv
// Purpose: E1 error counters, interval timer and CAS signaling buffers
// Assumes: Line events arrive as core-clock pulses from the framer
// Notes:   Control bits and the mask are plain inputs, no extra bus
// How it works
// - Mask bit one lets status interrupt through
// - Latch all counts each interval tick
// - Counters saturate, never wrap
// - Violation count: high byte first address
// - Type zero counts BPVs, skipping HDB3 codes
// - Type one counts code violations
// - Violation counter ignores sync loss
// - CRC counter halts on FAS/CRC loss
// - E bits zero in frames 13,15 counted
// - PRBS mode counts errors while synced
// - FAS counter halts on loss or search
// - Reads return rx (tx when readback select set), writes load tx
// - Rx signaling updated at multiframe boundary
// - Insert tx signaling only when enabled
// - Tx buffer copied to shifter each multiframe
// - Interval flag each second or 62.5ms
// - Rx multiframe flag every boundary
`timescale 1ns/100ps
module e1ecs_top
    import e1ecs_pkg::*;
#(
    parameter int unsigned INTERVAL_CYC = INTERVAL_CYCLES
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic [5:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_violation_type_select,
    input  wire logic       i_fast_interval_select,
    input  wire logic       i_signaling_readback_select,
    input  wire logic       i_tx_signaling_enable,
    input  wire logic       i_rx_hdb3_enable,
    input  wire logic [7:0] i_second_interrupt_mask,
    input  wire logic [7:0] i_status_clear,
    input  wire logic [7:0] i_status_set,
    output logic      [7:0] o_status2,
    output logic            o_int,
    input  wire logic       i_bpv,
    input  wire logic       i_bpv_pol,
    input  wire logic       i_bpv_hdb3,
    input  wire logic       i_crc_err,
    input  wire logic       i_ebit_stb,
    input  wire logic       i_ebit,
    input  wire logic [3:0] i_rx_frame,
    input  wire logic       i_prbs_en,
    input  wire logic       i_prbs_sync,
    input  wire logic       i_prbs_err,
    input  wire logic       i_fas_err,
    input  wire logic       i_rx_sync_lost,
    input  wire logic       i_fas_sync_lost,
    input  wire logic       i_crc_sync_lost,
    input  wire logic       i_align_search,
    input  wire logic       i_ts16_stb,
    input  wire logic [7:0] i_ts16_byte,
    input  wire logic       i_rx_mf_boundary,
    input  wire logic       i_tx_mf_boundary,
    input  wire logic [3:0] i_tx_frame,
    output logic      [7:0] o_ts16_byte,
    output logic            o_ts16_insert
);
    // ******************************************************
    // Interval timer
    // ******************************************************
    localparam logic [TMR_W-1:0] LONG_LAST  = TMR_W'(INTERVAL_CYC - 1);
    localparam logic [TMR_W-1:0] SHORT_LAST =
        TMR_W'(INTERVAL_CYC / FAST_DIV - 1);

    logic [TMR_W-1:0] tmr_r;
    logic             tick;

    assign tick = (tmr_r == (i_fast_interval_select ? SHORT_LAST
                                                    : LONG_LAST));

    always_ff @(posedge i_core_clk) begin
        if (i_rst || tick) begin
            tmr_r <= '0;
        end else begin
            tmr_r <= tmr_r + 1'b1;
        end
    end

    // ******************************************************
    // Event qualification
    // ******************************************************
    logic bpv_seen_r;
    logic bpv_pol_r;
    logic cv_evt;
    logic bpv_evt;
    logic frame_ok;
    logic [NUM_CNT-1:0] inc;

    // Code violation: this BPV matches the previous BPV polarity
    assign cv_evt  = i_bpv && bpv_seen_r && (i_bpv_pol == bpv_pol_r);
    assign bpv_evt = i_bpv && !(i_rx_hdb3_enable && i_bpv_hdb3);
    assign frame_ok = !i_fas_sync_lost && !i_crc_sync_lost;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            bpv_seen_r <= 1'b0;
            bpv_pol_r  <= 1'b0;
        end else if (i_bpv) begin
            bpv_seen_r <= 1'b1;
            bpv_pol_r  <= i_bpv_pol;
        end
    end

    always_comb begin
        // No sync term on the violation counter on purpose
        inc[CNT_VIOL] = i_violation_type_select ? cv_evt : bpv_evt;
        inc[CNT_CRC]  = i_crc_err && frame_ok;
        if (i_prbs_en) begin
            inc[CNT_FEBE] = i_prbs_err && i_prbs_sync;
        end else begin
            inc[CNT_FEBE] = i_ebit_stb && !i_ebit && frame_ok &&
                ((i_rx_frame == EBIT_FRAME_A) ||
                 (i_rx_frame == EBIT_FRAME_B));
        end
        inc[CNT_ALIGN] = i_fas_err && !i_rx_sync_lost &&
                         !i_align_search;
    end

    // ******************************************************
    // Counters
    // ******************************************************
    e1ecs_cnt_if cnt_bus [NUM_CNT] ();
    logic [CNT_W-1:0] snap [NUM_CNT];

    for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
        assign cnt_bus[g].inc  = inc[g];
        assign cnt_bus[g].tick = tick;
        assign snap[g]         = cnt_bus[g].snap;
        e1ecs_satcnt u_cnt (
            .i_core_clk (i_core_clk),
            .i_rst      (i_rst),
            .c          (cnt_bus[g])
        );
    end

    // ******************************************************
    // Status and interrupt
    // ******************************************************
    logic [7:0] status_r;
    logic [7:0] status_set;

    always_comb begin
        status_set          = i_status_set;
        status_set[RMF_BIT] = i_rx_mf_boundary;
        status_set[TMF_BIT] = i_tx_mf_boundary;
        status_set[SEC_BIT] = tick;
    end

    // A set in the clear cycle wins so no event is lost
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            status_r <= STATUS_RST;
        end else begin
            status_r <= (status_r & ~i_status_clear) | status_set;
        end
    end

    assign o_status2 = status_r;
    assign o_int     = |(status_r & i_second_interrupt_mask);

    // ******************************************************
    // Signaling buffers
    // ******************************************************
    logic [7:0] rx_shadow_r [NUM_SIG];
    logic [7:0] rx_buf_r    [NUM_SIG];
    logic [7:0] tx_buf_r    [NUM_SIG];
    logic [7:0] tx_shift_r  [NUM_SIG];
    logic       sig_hit;
    logic [3:0] sig_idx;

    assign sig_hit = (i_addr >= SIG_FIRST_OFS) && (i_addr <= SIG_LAST_OFS);
    assign sig_idx = i_addr[3:0];

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rx_shadow_r <= '{default: 8'h00};
        end else if (i_ts16_stb) begin
            rx_shadow_r[i_rx_frame] <= i_ts16_byte;
        end
    end

    // Host sees only whole multiframes, never a half-filled one
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rx_buf_r <= '{default: 8'h00};
        end else if (i_rx_mf_boundary) begin
            rx_buf_r <= rx_shadow_r;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            tx_buf_r <= '{default: 8'h00};
        end else if (i_wr && sig_hit) begin
            tx_buf_r[sig_idx] <= i_wdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            tx_shift_r <= '{default: 8'h00};
        end else if (i_tx_mf_boundary) begin
            tx_shift_r <= tx_buf_r;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_ts16_byte   <= 8'h00;
            o_ts16_insert <= 1'b0;
        end else begin
            o_ts16_byte   <= tx_shift_r[i_tx_frame];
            o_ts16_insert <= i_tx_signaling_enable;
        end
    end

    // ******************************************************
    // Host read port
    // ******************************************************
    function automatic logic [7:0] cnt_byte(input logic [15:0] v,
                                            input logic        lo);
        cnt_byte = lo ? v[7:0] : v[15:8];
    endfunction

    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        if (sig_hit) begin
            rd_mux = i_signaling_readback_select ? tx_buf_r[sig_idx]
                                                 : rx_buf_r[sig_idx];
        end else if (i_addr <= ALIGN_LO_OFS) begin
            rd_mux = cnt_byte(snap[i_addr[2:1]], i_addr[0]);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= rd_mux;
        end
    end

    // ******************************************************
    // Checks
    // ******************************************************
    sequence s_rx_mf;
        i_rx_mf_boundary;
    endsequence
    sequence s_rx_flag;
        status_r[RMF_BIT] && rx_buf_r[0] == $past(rx_shadow_r[0]);
    endsequence
    // Boundary, then frame zero presented on the next cycle
    sequence s_tx_mf_frame0;
        i_tx_mf_boundary ##1 (i_tx_frame == 4'h0);
    endsequence

    a_mask_gate: assert property (@(posedge i_core_clk)
        disable iff (i_rst) o_int == |(o_status2 & i_second_interrupt_mask))
        else $error("interrupt not gated by mask");
    a_rx_mf_update: assert property (@(posedge i_core_clk)
        disable iff (i_rst) s_rx_mf |=> s_rx_flag)
        else $error("rx signaling not updated at boundary");
    a_rx_buf_hold: assert property (@(posedge i_core_clk)
        disable iff (i_rst) !i_rx_mf_boundary |=> $stable(rx_buf_r[0]))
        else $error("rx signaling changed off boundary");
    a_tx_copy: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        s_tx_mf_frame0 |=> o_ts16_byte == $past(tx_buf_r[0], 2))
        else $error("tx shifter not loaded");
    a_ins_enable: assert property (@(posedge i_core_clk)
        disable iff (i_rst) !i_tx_signaling_enable |=> !o_ts16_insert)
        else $error("insertion without enable");
    a_sec_flag: assert property (@(posedge i_core_clk)
        disable iff (i_rst) tick |=> status_r[SEC_BIT] && tmr_r == '0)
        else $error("interval flag not set on tick");
    a_viol_type: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (i_violation_type_select && i_bpv && !bpv_seen_r)
        |-> !inc[CNT_VIOL])
        else $error("first violation counted as code violation");
    a_crc_halt: assert property (@(posedge i_core_clk)
        disable iff (i_rst) (i_fas_sync_lost || i_crc_sync_lost) |->
        !inc[CNT_CRC] && (i_prbs_en || !inc[CNT_FEBE]))
        else $error("crc or ebit counted during sync loss");
    a_fas_halt: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (i_rx_sync_lost || i_align_search) |-> !inc[CNT_ALIGN])
        else $error("fas error counted while out of sync");
    a_viol_hdb3: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (!i_violation_type_select && i_rx_hdb3_enable && i_bpv_hdb3)
        |-> !inc[CNT_VIOL])
        else $error("hdb3 codeword counted as violation");
endmodule

// >>> bench/e1ecs_host.sv
// Purpose: Host processor model on the byte-wide register port
// Assumes: Requests launch at the falling edge, held over one rising edge
// Notes:   Read data is taken a full cycle after the strobe
`timescale 1ns/100ps
module e1ecs_host (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_rdata,
    output logic      [5:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr,
    output logic            o_rd
);
    initial begin
        o_addr = 6'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // Tx signaling updates follow each tx multiframe, all within 2ms
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_core_clk);
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask

    // Caller reads counts and rx signaling right after each update
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge i_core_clk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_core_clk);
        o_rd = 1'b0;
        @(negedge i_core_clk);
        d = i_rdata;
    endtask
endmodule

// >>> bench/e1ecs_tb_top.sv
// Purpose: Self-checking bench for the E1 counters and signaling
// Assumes: Long interval of 65552 cycles, fast interval of 4097
// Notes:   Integer model of every counter, compared per interval
`timescale 1ns/100ps
module e1ecs_tb_top
    import e1ecs_pkg::*;
;
    localparam int unsigned IV = 65552;
    logic       clk, rst, vts, fis, rbs, tse, hdb, bpv, bpol, bhdb;
    logic       crc, est, eb, pen, psy, perr, fas, rsl, fsl, csl, asr;
    logic       tstb, rx_cas_multiframe_flag, tx_multiframe_flag, wr, rd, o_int, ins;
    logic [3:0] frm, tfrm;
    logic [5:0] addr;
    logic [7:0] mask, sclr, sset, tbyte, wd, rdat, st, ts, b;
    logic [7:0] sb[16], rb[16];
    logic [15:0] v;
    int          mc[4];
    int          miscompares, n_checks, cyc, t0, t1;
    integer      seed;
    bit          pv, pv_ok;

    e1ecs_host e1ecs_host_i (.i_core_clk(clk), .i_rdata(rdat),
        .o_addr(addr), .o_wdata(wd), .o_wr(wr), .o_rd(rd));

    e1ecs_top #(.INTERVAL_CYC(IV)) e1ecs_top_i (.i_core_clk(clk),
        .i_rst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdat), .i_violation_type_select(vts),
        .i_fast_interval_select(fis), .i_signaling_readback_select(rbs),
        .i_tx_signaling_enable(tse), .i_rx_hdb3_enable(hdb),
        .i_second_interrupt_mask(mask), .i_status_clear(sclr),
        .i_status_set(sset), .o_status2(st), .o_int(o_int), .i_bpv(bpv),
        .i_bpv_pol(bpol), .i_bpv_hdb3(bhdb), .i_crc_err(crc),
        .i_ebit_stb(est), .i_ebit(eb), .i_rx_frame(frm), .i_prbs_en(pen),
        .i_prbs_sync(psy), .i_prbs_err(perr), .i_fas_err(fas),
        .i_rx_sync_lost(rsl), .i_fas_sync_lost(fsl),
        .i_crc_sync_lost(csl), .i_align_search(asr), .i_ts16_stb(tstb),
        .i_ts16_byte(tbyte), .i_rx_mf_boundary(rx_cas_multiframe_flag),
        .i_tx_mf_boundary(tx_multiframe_flag), .i_tx_frame(tfrm), .o_ts16_byte(ts),
        .o_ts16_insert(ins));

    // ******************************************************
    // Clock, run limit and shared tasks
    // ******************************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Ceiling: long interval plus five fast ones and some margin
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 95000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic pulse(input logic [7:0] clr, input logic [7:0] set);
        @(negedge clk);
        sclr = clr;
        sset = set;
        @(negedge clk);
        sclr = 8'h00;
        sset = 8'h00;
    endtask

    // Sticky timer flag is cleared first, so only a new tick is seen
    task automatic wait_tick(output int t);
        int n;
        pulse(8'h10, 8'h00);
        n = 0;
        while (st[SEC_BIT] !== 1'b1 && n < 70000) begin
            @(negedge clk);
            n++;
        end
        // A tick that never comes is a failure, not a pass
        if (n >= 70000) miscompares++;
        t = cyc;
    endtask

    task automatic read_counts();
        for (int k = 0; k < 4; k++) begin
            e1ecs_host_i.rd(6'(2 * k), v[15:8]);
            e1ecs_host_i.rd(6'(2 * k + 1), v[7:0]);
            chk(v, 16'(mc[k]));
        end
    endtask

    task automatic inc(input int k);
        if (mc[k] < 65535) mc[k]++;
    endtask

    // Random line events and sync levels, mirrored into the model
    task automatic inject(input int n);
        logic [31:0] r;
        mc = '{0, 0, 0, 0};
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            r = $random(seed);
            {bpv, bpol, bhdb, crc, est, eb, perr, fas, asr, psy} = r[9:0];
            fsl = r[12:10] == 3'h0;
            csl = r[15:13] == 3'h0;
            rsl = fsl;
            frm = r[19:16];
            if (bpv && vts && pv_ok && bpol == pv) inc(0);
            if (bpv && !vts && !(hdb && bhdb)) inc(0);
            if (bpv) pv = bpol;
            pv_ok |= bpv;
            if (crc && !fsl && !csl) inc(1);
            if (pen && perr && psy) inc(2);
            if (!pen && est && !eb && !fsl && !csl &&
                (frm == EBIT_FRAME_A || frm == EBIT_FRAME_B)) inc(2);
            if (fas && !rsl && !asr) inc(3);
        end
        @(negedge clk);
        {bpv, bhdb, crc, est, perr, fas, fsl, csl, rsl, asr} = '0;
    endtask

    // ******************************************************
    // Main sequence
    // ******************************************************
    initial begin
        seed = 32'h7c68;
        {vts, fis, rbs, tse, hdb, bpv, bpol, bhdb, crc, est, eb, pen} = '0;
        {psy, perr, fas, rsl, fsl, csl, asr, tstb, rx_cas_multiframe_flag, tx_multiframe_flag} = '0;
        {frm, tfrm, mask, sclr, sset, tbyte} = '0;
        {miscompares, n_checks, cyc, pv, pv_ok} = '0;
        mc = '{0, 0, 0, 0};
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        read_counts();
        e1ecs_host_i.wr(VIOL_LO_OFS, 8'h5a);
        e1ecs_host_i.rd(VIOL_LO_OFS, b);
        chk(b, 8'h00);
        e1ecs_host_i.rd(6'h10, b);
        chk(b, 8'h00);
        // CV counting first: no polarity history before it
        fis = 1'b1;
        vts = 1'b1;
        hdb = 1'b1;
        wait_tick(t0);
        inject(3000);
        wait_tick(t1);
        chk(16'(t1 - t0), 16'(IV / FAST_DIV));
        read_counts();
        vts = 1'b0;
        hdb = 1'b1;
        pen = 1'b1;
        wait_tick(t0);
        inject(3000);
        wait_tick(t1);
        read_counts();
        pulse(8'h00, 8'h4f);
        @(negedge clk);
        {rx_cas_multiframe_flag, tx_multiframe_flag} = 2'b11;
        @(negedge clk);
        {rx_cas_multiframe_flag, tx_multiframe_flag} = 2'b00;
        chk(st, 8'hff);
        for (int k = 0; k < 8; k++) begin
            mask = 8'(1 << k);
            @(negedge clk);
            chk(o_int, 1'b1);
        end
        mask = 8'h00;
        @(negedge clk);
        chk(o_int, 1'b0);
        pulse(8'hff, 8'h00);
        chk(st & 8'hef, 8'h00);
        // Signaling: tx buffer loaded by host, rx buffer from slot 16
        for (int k = 0; k < 16; k++) begin
            sb[k] = $random(seed);
            rb[k] = $random(seed);
            if (k == 0) sb[0][7:4] = 4'h0;
            e1ecs_host_i.wr(SIG_FIRST_OFS + 6'(k), sb[k]);
        end
        rbs = 1'b1;
        for (int k = 0; k < 16; k++) begin
            e1ecs_host_i.rd(SIG_FIRST_OFS + 6'(k), b);
            chk(b, sb[k]);
        end
        rbs = 1'b0;
        for (int k = 0; k < 16; k++) begin
            @(negedge clk);
            tstb = 1'b1;
            frm = 4'(k);
            tbyte = rb[k];
        end
        @(negedge clk);
        tstb = 1'b0;
        e1ecs_host_i.rd(SIG_LAST_OFS, b);
        chk(b, 8'h00);
        @(negedge clk);
        rx_cas_multiframe_flag = 1'b1;
        @(negedge clk);
        rx_cas_multiframe_flag = 1'b0;
        chk(st[RMF_BIT], 1'b1);
        for (int k = 0; k < 16; k++) begin
            e1ecs_host_i.rd(SIG_FIRST_OFS + 6'(k), b);
            chk(b, rb[k]);
        end
        tse = 1'b1;
        @(negedge clk);
        tx_multiframe_flag = 1'b1;
        @(negedge clk);
        tx_multiframe_flag = 1'b0;
        e1ecs_host_i.wr(SIG_FIRST_OFS + 6'h5, ~sb[5]);
        for (int k = 0; k < 17; k++) begin
            @(negedge clk);
            if (k > 0) chk(ts, sb[k - 1]);
            if (k < 16) tfrm = 4'(k);
        end
        chk(ins, 1'b1);
        tse = 1'b0;
        repeat (2) @(negedge clk);
        chk(ins, 1'b0);
        // Saturation over one long interval, sync lost throughout
        wait_tick(t0);
        fis = 1'b0;
        {bpv, rsl, fsl} = 3'b111;
        wait_tick(t1);
        {bpv, rsl, fsl} = 3'b000;
        chk(16'(t1 - t0), 16'(IV));
        mc = '{65535, 0, 0, 0};
        read_counts();
        complete_run();
    end
endmodule
